// *** list_step_trigger_wait_tb_top.sv ***
// Self-checking bench of the list-step wait block
`timescale 1ns/100ps
`include "lstw_defs.vh"
module list_step_trigger_wait_tb_top;
  localparam HF = 20;
  localparam LF = 5;
  reg clk_sys = 1'b0;
  reg arst_n = 1'b0;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [7:0] wb_adr_i = 8'h00;
  reg [3:0] wb_sel_i = 4'hF;
  reg [31:0] wb_dat_i = 32'h0000_0000;
  wire [31:0] wb_dat_o;
  wire wb_ack_o;
  wire trig_in;
  wire [15:0] out_level_ff;
  wire step_advance_ff;
  wire irq;
  integer num_errors = 0;
  integer n_tests = 0;
  integer adv_cnt = 0;
  integer n0 = 0;
  reg [31:0] rd;
  lstw_list_wait #(.LEVEL_MAX(16'h1000), .LEVEL_MIN(16'hF000), .HIGH_FILT_CYC(HF), .LOW_FILT_CYC(LF)) dut (
    .clk_sys, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .trig_in, .out_level_ff, .step_advance_ff, .irq);
  lstw_trig_src #(.MIN_HOLD(HF + 8)) u_trig (.clk_sys, .trig_in);
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (step_advance_ff === 1'b1) adv_cnt <= adv_cnt + 1;
  // ----
  // Bus and compare helpers
  // ----
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      @(posedge clk_sys);
      while (wb_ack_o !== 1'b1 && n < 50) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      if (n == 50) chk(32'h0000_0000, 32'h0000_0001);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_sys);
    end
  endtask
  task rdchk(input [7:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, e);
    end
  endtask
  task cmd(input [3:0] c);
    bus(1'b1, `LSTW_ADR_CMD, {28'h0000000, c});
  endtask
  task errc(input [3:0] c, input [31:0] e, input i);
    begin
      bus(1'b1, `LSTW_ADR_IRQ_CLR, 32'h0000_0007);
      cmd(c);
      chk({31'h00000000, irq}, {31'h00000000, i});
      bus(1'b0, `LSTW_ADR_ERR, 32'h0000_0000);
      chk({16'h0000, rd[15:0]}, e);
    end
  endtask
  task sq(input [31:0] s, input [31:0] p);
    begin
      cmd(`LSTW_CMD_SWEEP_QUERY);
      rdchk(`LSTW_ADR_RESULT, s);
      rdchk(`LSTW_ADR_RESULT2, p);
    end
  endtask
  task wstep(input lvl, input [31:0] w, input [3:0] c, input [31:0] nadv);
    begin
      u_trig.hold(lvl, 0);
      bus(1'b1, `LSTW_ADR_WAIT, w);
      bus(1'b1, `LSTW_ADR_ARG, {28'h0000000, c} + 32'h0000_0100);
      n0 = adv_cnt;
      cmd(c);
      chk(adv_cnt - n0, nadv);
      chk({16'h0000, out_level_ff}, {28'h0000000, c} + 32'h0000_0100);
    end
  endtask
  task wadv(input integer cyc, input [31:0] e);
    begin
      repeat (cyc) @(posedge clk_sys);
      chk(adv_cnt - n0, e);
    end
  endtask
  // ----
  // Scenarios
  // ----
  task t_sweep;
    begin
      sq(32'h0000_0001, 32'h0000_8CA0);
      bus(1'b1, `LSTW_ADR_SWEEP, 32'h8CA1_0001);
      sq(32'h0000_0001, 32'h0000_8CA0);
      bus(1'b1, `LSTW_ADR_SWEEP, 32'h0001_8CA0);
      sq(32'h0000_8CA0, 32'h0000_0001);
      rdchk(8'h3C, 32'h0000_0000);
    end
  endtask
  task t_list;
    integer i;
    begin
      cmd(`LSTW_CMD_CLEAR);
      for (i = 0; i < 5; i = i + 1) cmd(`LSTW_CMD_APPEND_VOLT);
      cmd(`LSTW_CMD_POINT_QUERY);
      rdchk(`LSTW_ADR_RESULT, 32'h0000_0005);
      cmd(`LSTW_CMD_CLEAR);
      cmd(`LSTW_CMD_POINT_QUERY);
      rdchk(`LSTW_ADR_RESULT, 32'h0000_0000);
    end
  endtask
  task t_level;
    begin
      bus(1'b1, `LSTW_ADR_ARG, 32'h0000_1001);
      errc(`LSTW_CMD_SET_LEVEL, 32'h0000_FF22, 1'b0);
      rdchk(`LSTW_ADR_LEVEL, 32'h0000_0000);
      bus(1'b1, `LSTW_ADR_IRQ_EN, 32'h0000_0004);
      bus(1'b1, `LSTW_ADR_ARG, 32'h0000_EFFF);
      errc(`LSTW_CMD_SET_LEVEL, 32'h0000_FF22, 1'b1);
      bus(1'b1, `LSTW_ADR_ARG, 32'h0000_0ABC);
      cmd(`LSTW_CMD_SET_LEVEL);
      rdchk(`LSTW_ADR_LEVEL, 32'h0000_0ABC);
      cmd(`LSTW_CMD_LEVEL_QUERY);
      rdchk(`LSTW_ADR_RESULT, 32'h0000_0ABC);
      cmd(`LSTW_CMD_LEVEL_MAX_QUERY);
      rdchk(`LSTW_ADR_RESULT, 32'h0000_1000);
      cmd(`LSTW_CMD_LEVEL_MIN_QUERY);
      rdchk(`LSTW_ADR_RESULT, 32'hFFFF_F000);
    end
  endtask
  task t_err;
    begin
      cmd(`LSTW_CMD_CLEAR);
      errc(`LSTW_CMD_WAIT_HIGH, 32'h0000_FF23, 1'b1);
      cmd(`LSTW_CMD_APPEND_CURR);
      errc(`LSTW_CMD_POINT_QUERY, 32'h0000_FF23, 1'b1);
      cmd(`LSTW_CMD_CLEAR);
      cmd(`LSTW_CMD_APPEND_VOLT);
      errc(`LSTW_CMD_POINT_QUERY, 32'h0000_FF23, 1'b0);
      cmd(`LSTW_CMD_APPEND_VOLT);
      bus(1'b1, `LSTW_ADR_DWELL, 32'h0000_0001);
      errc(`LSTW_CMD_WAIT_HIGH, 32'h0000_FF1E, 1'b1);
      errc(`LSTW_CMD_WAIT_FALL, 32'h0000_FF1E, 1'b1);
      errc(`LSTW_CMD_WAIT_LOW, 32'h0000_FF14, 1'b1);
      bus(1'b1, `LSTW_ADR_IRQ_CLR, 32'h0000_0007);
      chk({31'h00000000, irq}, 32'h0000_0000);
    end
  endtask
  task t_waits;
    begin
      cmd(`LSTW_CMD_CLEAR);
      cmd(`LSTW_CMD_APPEND_VOLT);
      wstep(1'b1, 32'h0000_0008, `LSTW_CMD_WAIT_HIGH, 32'h0000_0001);
      wstep(1'b0, 32'h0000_0008, `LSTW_CMD_WAIT_LOW, 32'h0000_0001);
      wstep(1'b0, 32'h0000_000A, `LSTW_CMD_WAIT_HIGH, 32'h0000_0000);
      wadv(20, 32'h0000_0001);
      wstep(1'b1, 32'h0000_000A, `LSTW_CMD_WAIT_LOW, 32'h0000_0000);
      wadv(20, 32'h0000_0001);
      wstep(1'b0, 32'h0000_0000, `LSTW_CMD_WAIT_HIGH, 32'h0000_0000);
      wadv(60, 32'h0000_0000);
      rdchk(`LSTW_ADR_STAT, 32'h0000_0003);
      u_trig.hold(1'b1, 0);
      wadv(10, 32'h0000_0001);
      wstep(1'b1, 32'h0000_0000, `LSTW_CMD_WAIT_LOW, 32'h0000_0000);
      wadv(40, 32'h0000_0000);
      u_trig.hold(1'b0, 0);
      wadv(4, 32'h0000_0001);
      wstep(1'b0, 32'h0000_0000, `LSTW_CMD_WAIT_FALL, 32'h0000_0000);
      wadv(60, 32'h0000_0000);
      u_trig.hold(1'b1, 0);
      wadv(2, 32'h0000_0000);
      u_trig.hold(1'b0, 0);
      wadv(4, 32'h0000_0001);
      wstep(1'b1, 32'h0000_000A, `LSTW_CMD_WAIT_FALL, 32'h0000_0000);
      wadv(20, 32'h0000_0001);
      wstep(1'b1, 32'h0000_0064, `LSTW_CMD_WAIT_FALL, 32'h0000_0000);
      u_trig.hold(1'b0, 0);
      // Checked well before the 100-cycle timeout, so only the edge can have advanced it
      wadv(2, 32'h0000_0001);
    end
  endtask
  task t_reset;
    begin
      @(posedge clk_sys);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk({16'h0000, out_level_ff}, 32'h0000_0000);
      chk({31'h00000000, irq}, 32'h0000_0000);
      arst_n <= 1'b1;
      rdchk(`LSTW_ADR_LEVEL, 32'h0000_0000);
      rdchk(`LSTW_ADR_SWEEP, 32'h8CA0_0001);
      cmd(`LSTW_CMD_POINT_QUERY);
      rdchk(`LSTW_ADR_RESULT, 32'h0000_0000);
    end
  endtask
  task final_report;
    begin
      if (num_errors == 0 && n_tests > 0) begin
        $display("All checks passed");
      end else begin
        $display("Checks failed");
      end
      $finish;
    end
  endtask
  initial begin
    #300000;
    num_errors = num_errors + 1;
    final_report;
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_sweep;
    t_list;
    t_level;
    t_err;
    t_waits;
    t_reset;
    final_report;
  end
endmodule

// *** lstw_checker.sv ***
// Checker for bus handshake, output level, trigger filter and step timeout
`timescale 1ns/100ps
`include "lstw_defs.vh"
module lstw_checker #(
  parameter HIGH_FILT_CYC = 20,
  parameter LOW_FILT_CYC = 5
) (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Register bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Trigger, output stage and interrupt
  input wire trig_in,
  input wire [15:0] out_level_ff,
  input wire step_advance_ff,
  input wire irq
);
  wire wr_take = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  wire cmd_wait = wr_take && wb_adr_i == `LSTW_ADR_CMD && wb_dat_i[3:0] >= `LSTW_CMD_WAIT_HIGH
    && wb_dat_i[3:0] <= `LSTW_CMD_WAIT_LOW;
  reg [15:0] arg_ff;
  reg [31:0] wait_ff;
  reg [2:0] en_ff;
  reg [3:0] mode_ff;
  reg waiting_ff;
  reg [31:0] since_ff;
  reg [15:0] hi_run_ff;
  reg [15:0] lo_run_ff;
  // ----
  // Shadow state; raw pin run lengths are an upper bound on the filtered view
  // ----
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      arg_ff <= 16'h0000;
      wait_ff <= 32'h0000_0000;
      en_ff <= 3'h0;
      mode_ff <= 4'h0;
      waiting_ff <= 1'b0;
      since_ff <= 32'h0000_0000;
      hi_run_ff <= 16'h0000;
      lo_run_ff <= 16'h0000;
    end else begin
      hi_run_ff <= trig_in ? hi_run_ff + {15'h0000, ~&hi_run_ff} : 16'h0000;
      lo_run_ff <= trig_in ? 16'h0000 : lo_run_ff + {15'h0000, ~&lo_run_ff};
      since_ff <= since_ff + 32'h0000_0001;
      if (wr_take && wb_adr_i == `LSTW_ADR_ARG) arg_ff <= wb_dat_i[15:0];
      if (wr_take && wb_adr_i == `LSTW_ADR_IRQ_EN) en_ff <= wb_dat_i[2:0];
      if (wr_take && wb_adr_i == `LSTW_ADR_WAIT) wait_ff <= wb_dat_i;
      if (step_advance_ff || (wr_take && wb_adr_i == `LSTW_ADR_WAIT)) waiting_ff <= 1'b0;
      if (cmd_wait && !waiting_ff) begin
        waiting_ff <= 1'b1;
        mode_ff <= wb_dat_i[3:0];
        since_ff <= 32'h0000_0000;
      end
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not acknowledged next cycle");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_level_src;
    $changed(out_level_ff) |-> out_level_ff == arg_ff && (wb_ack_o || $past(wb_ack_o));
  endproperty
  a_level_src: assert property (p_level_src) else $error("level changed without command");
  property p_adv_cause;
    step_advance_ff |-> waiting_ff;
  endproperty
  a_adv_cause: assert property (p_adv_cause) else $error("advance outside a wait step");
  property p_high_filt;
    step_advance_ff && wait_ff == 0 && mode_ff == `LSTW_CMD_WAIT_HIGH |-> hi_run_ff >= HIGH_FILT_CYC;
  endproperty
  a_high_filt: assert property (p_high_filt) else $error("high wait ended early");
  property p_low_filt;
    step_advance_ff && wait_ff == 0 && mode_ff == `LSTW_CMD_WAIT_LOW |-> lo_run_ff >= LOW_FILT_CYC;
  endproperty
  a_low_filt: assert property (p_low_filt) else $error("low wait ended early");
  property p_fall_filt;
    step_advance_ff && wait_ff == 0 && mode_ff == `LSTW_CMD_WAIT_FALL |-> lo_run_ff >= HIGH_FILT_CYC;
  endproperty
  a_fall_filt: assert property (p_fall_filt) else $error("edge wait ended early");
  property p_timeout;
    waiting_ff && wait_ff != 0 |-> since_ff <= wait_ff + 4;
  endproperty
  a_timeout: assert property (p_timeout) else $error("wait time overrun");
  property p_irq_mask;
    en_ff == 3'h0 && $past(en_ff) == 3'h0 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt while all masked");
endmodule
bind lstw_list_wait lstw_checker #(.HIGH_FILT_CYC(HIGH_FILT_CYC), .LOW_FILT_CYC(LOW_FILT_CYC)) u_checker (
  .clk_sys, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .trig_in, .out_level_ff, .step_advance_ff, .irq);

// *** lstw_defs.vh ***
// Register map, field layout, codes and timing constants of the list-step wait block
`ifndef LSTW_DEFS_VH
`define LSTW_DEFS_VH

// ----------------------------------------
// Register word addresses (byte offsets)
// ----------------------------------------
`define LSTW_ADR_CMD 8'h00
`define LSTW_ADR_ARG 8'h04
`define LSTW_ADR_STAT 8'h08
`define LSTW_ADR_RESULT 8'h0C
`define LSTW_ADR_RESULT2 8'h10
`define LSTW_ADR_WAIT 8'h14
`define LSTW_ADR_DWELL 8'h18
`define LSTW_ADR_LEVEL 8'h1C
`define LSTW_ADR_ERR 8'h20
`define LSTW_ADR_IRQ_STAT 8'h24
`define LSTW_ADR_IRQ_CLR 8'h28
`define LSTW_ADR_IRQ_EN 8'h2C
`define LSTW_ADR_SWEEP 8'h30

// ----------------------------------------
// Command codes written to CMD
// ----------------------------------------
`define LSTW_CMD_CLEAR 4'h1
`define LSTW_CMD_APPEND_VOLT 4'h2
`define LSTW_CMD_APPEND_CURR 4'h3
`define LSTW_CMD_POINT_QUERY 4'h4
`define LSTW_CMD_SWEEP_QUERY 4'h5
`define LSTW_CMD_WAIT_HIGH 4'h6
`define LSTW_CMD_WAIT_FALL 4'h7
`define LSTW_CMD_WAIT_LOW 4'h8
`define LSTW_CMD_SET_LEVEL 4'h9
`define LSTW_CMD_LEVEL_QUERY 4'hA
`define LSTW_CMD_LEVEL_MAX_QUERY 4'hB
`define LSTW_CMD_LEVEL_MIN_QUERY 4'hC

// ----------------------------------------
// Error codes, two's complement 16 bit
// ----------------------------------------
`define LSTW_ERR_NONE 16'h0000
`define LSTW_ERR_CONFLICT 16'hFF23
`define LSTW_ERR_RANGE 16'hFF22
`define LSTW_ERR_LEN_HIGH 16'hFF1E
`define LSTW_ERR_LEN_LOW 16'hFF14

// ----------------------------------------
// Status and interrupt bit positions
// ----------------------------------------
`define LSTW_ST_BUSY 0
`define LSTW_ST_LIST_VOLT 1
`define LSTW_ST_APPEND_CURRENT_POINT 2
`define LSTW_ST_TRIG 3
`define LSTW_IRQ_DONE 0
`define LSTW_IRQ_STEP 1
`define LSTW_IRQ_ERR 2
`define LSTW_IRQ_W 3

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define LSTW_RST_LEVEL 16'h0000
`define LSTW_RST_START_ANG 16'h0001
`define LSTW_RST_STOP_ANG 16'h8CA0
`define LSTW_ANG_MIN 16'h0001
`define LSTW_ANG_MAX 16'h8CA0

// ----------------------------------------
// Trigger filter times
// ----------------------------------------
`define LSTW_CLK_HZ 50000000
`define LSTW_HIGH_FILT_NS 400000
`define LSTW_LOW_FILT_NS 2000
`define LSTW_HIGH_FILT_CYC ((`LSTW_HIGH_FILT_NS * (`LSTW_CLK_HZ / 1000000) + 999) / 1000)
`define LSTW_LOW_FILT_CYC ((`LSTW_LOW_FILT_NS * (`LSTW_CLK_HZ / 1000000) + 999) / 1000)

`endif

// *** lstw_list_wait.v ***
// List-step sequencer and level command handler with Wishbone register access
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/100ps
`include "lstw_defs.vh"
module lstw_list_wait #(
  parameter PTR_W = 13,
  parameter [15:0] LEVEL_MAX = 16'h7FFF,
  parameter [15:0] LEVEL_MIN = 16'h8001,
  parameter HIGH_FILT_CYC = `LSTW_HIGH_FILT_CYC,
  parameter LOW_FILT_CYC = `LSTW_LOW_FILT_CYC
) (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Trigger pin
  input wire trig_in,
  // Output stage
  output reg [15:0] out_level_ff,
  output reg step_advance_ff,
  // Interrupt
  output wire irq
);

  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;

  localparam [1:0] WT_HIGH = 2'd0;
  localparam [1:0] WT_FALL = 2'd1;
  localparam [1:0] WT_LOW = 2'd2;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [31:0] wmask;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] sel;
    integer i;
    begin
      wmask = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          wmask[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  function ang_ok;
    input [15:0] a;
    begin
      ang_ok = (a >= `LSTW_ANG_MIN) && (a <= `LSTW_ANG_MAX);
    end
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [31:0] arg_ff;
  reg [31:0] result_ff;
  reg [31:0] result2_ff;
  reg [31:0] wait_ff;
  reg [PTR_W-1:0] dwell_ff;
  reg [15:0] level_ff;
  reg [15:0] err_ff;
  reg [2:0] irq_stat_ff;
  reg [2:0] irq_en_ff;
  reg [15:0] start_ang_ff;
  reg [15:0] stop_ang_ff;
  reg [PTR_W-1:0] ptr_ff;
  reg list_volt_ff;
  reg append_current_point_ff;
  reg [1:0] state_ff;
  reg [1:0] wtype_ff;
  reg [31:0] wcnt_ff;

  // ----------------------------------------
  // Trigger filters: one for the high and falling-edge waits, one for the low wait
  // ----------------------------------------
  wire hi_stable;
  wire hi_fall;
  wire lo_stable;

  lstw_trig_filter #(.CNT_W(15)) u_filt_high (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .trig_pin(trig_in),
    .filt_cyc(HIGH_FILT_CYC[14:0]),
    .stable_ff(hi_stable),
    .fall(hi_fall)
  );

  lstw_trig_filter #(.CNT_W(15)) u_filt_low (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .trig_pin(trig_in),
    .filt_cyc(LOW_FILT_CYC[14:0]),
    .stable_ff(lo_stable),
    .fall()
  );

  // ----------------------------------------
  // Bus decode; ack answers one cycle after the strobe
  // ----------------------------------------
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire rd = req & ~wb_we_i;
  wire cmd_wr = wr & (wb_adr_i == `LSTW_ADR_CMD) & wb_sel_i[0];
  wire [3:0] cmd = wb_dat_i[3:0];
  wire busy = (state_ff == ST_WAIT);
  wire [15:0] arg16 = arg_ff[15:0];

  // All new commands, level reads included, are refused while a step waits
  wire do_cmd = cmd_wr & ~busy;
  wire is_wait = (cmd == `LSTW_CMD_WAIT_HIGH) | (cmd == `LSTW_CMD_WAIT_FALL) | (cmd == `LSTW_CMD_WAIT_LOW);
  wire has_list = list_volt_ff | append_current_point_ff;
  wire len_bad = (dwell_ff != ptr_ff);

  // ----------------------------------------
  // Wait step completion
  // ----------------------------------------
  wire timeout = (wait_ff != 32'h0000_0000) && (wcnt_ff >= wait_ff);
  reg step_done;
  always @* begin
    step_done = 1'b0;
    case (wtype_ff)
      WT_HIGH: step_done = hi_stable | timeout;
      WT_FALL: step_done = hi_fall | timeout;
      WT_LOW: step_done = ~lo_stable | timeout;
      default: step_done = 1'b1;
    endcase
  end

  // ----------------------------------------
  // Command execution and state
  // ----------------------------------------
  reg [15:0] nxt_err;
  reg err_evt;
  always @* begin
    nxt_err = `LSTW_ERR_NONE;
    err_evt = 1'b0;
    if (do_cmd) begin
      case (cmd)
        `LSTW_CMD_POINT_QUERY: begin
          if (append_current_point_ff) begin
            nxt_err = `LSTW_ERR_CONFLICT;
            err_evt = 1'b1;
          end
        end
        `LSTW_CMD_APPEND_VOLT: begin
          if (append_current_point_ff) begin
            nxt_err = `LSTW_ERR_CONFLICT;
            err_evt = 1'b1;
          end
        end
        `LSTW_CMD_SET_LEVEL: begin
          if ($signed(arg16) > $signed(LEVEL_MAX) || $signed(arg16) < $signed(LEVEL_MIN)) begin
            nxt_err = `LSTW_ERR_RANGE;
            err_evt = 1'b1;
          end
        end
        `LSTW_CMD_WAIT_HIGH, `LSTW_CMD_WAIT_FALL, `LSTW_CMD_WAIT_LOW: begin
          if (!has_list) begin
            nxt_err = `LSTW_ERR_CONFLICT;
            err_evt = 1'b1;
          end else if (len_bad) begin
            nxt_err = (cmd == `LSTW_CMD_WAIT_LOW) ? `LSTW_ERR_LEN_LOW : `LSTW_ERR_LEN_HIGH;
            err_evt = 1'b1;
          end
        end
        default: begin
          nxt_err = `LSTW_ERR_NONE;
        end
      endcase
    end else if (cmd_wr) begin
      nxt_err = `LSTW_ERR_CONFLICT;
      err_evt = 1'b1;
    end
  end

  wire wait_ok = do_cmd & is_wait & ~err_evt;
  wire tmr = (wait_ff != 32'h0000_0000);
  wire skip_now = wait_ok & tmr &
    (((cmd == `LSTW_CMD_WAIT_HIGH) & hi_stable) | ((cmd == `LSTW_CMD_WAIT_LOW) & ~lo_stable));
  wire step_evt = skip_now | (busy & step_done);

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
      wtype_ff <= WT_HIGH;
      wcnt_ff <= 32'h0000_0000;
      ptr_ff <= {PTR_W{1'b0}};
      list_volt_ff <= 1'b0;
      append_current_point_ff <= 1'b0;
      level_ff <= `LSTW_RST_LEVEL;
      out_level_ff <= `LSTW_RST_LEVEL;
      result_ff <= 32'h0000_0000;
      result2_ff <= 32'h0000_0000;
      err_ff <= `LSTW_ERR_NONE;
      step_advance_ff <= 1'b0;
    end else begin
      step_advance_ff <= step_evt;
      if (err_evt) begin
        err_ff <= nxt_err;
      end
      if (busy) begin
        wcnt_ff <= wcnt_ff + 32'h0000_0001;
        if (step_done) begin
          state_ff <= ST_IDLE;
        end
      end
      if (do_cmd) begin
        case (cmd)
          `LSTW_CMD_CLEAR: begin
            ptr_ff <= {PTR_W{1'b0}};
            list_volt_ff <= 1'b0;
            append_current_point_ff <= 1'b0;
          end
          `LSTW_CMD_APPEND_VOLT: begin
            if (!append_current_point_ff) begin
              ptr_ff <= ptr_ff + {{(PTR_W-1){1'b0}}, 1'b1};
              list_volt_ff <= 1'b1;
            end
          end
          `LSTW_CMD_APPEND_CURR: begin
            if (!list_volt_ff) begin
              ptr_ff <= ptr_ff + {{(PTR_W-1){1'b0}}, 1'b1};
              append_current_point_ff <= 1'b1;
            end
          end
          `LSTW_CMD_POINT_QUERY: begin
            result_ff <= {{(32-PTR_W){1'b0}}, ptr_ff};
          end
          `LSTW_CMD_SWEEP_QUERY: begin
            result_ff <= {16'h0000, start_ang_ff};
            result2_ff <= {16'h0000, stop_ang_ff};
          end
          `LSTW_CMD_SET_LEVEL: begin
            if (!err_evt) begin
              level_ff <= arg16;
              out_level_ff <= arg16;
            end
          end
          `LSTW_CMD_LEVEL_QUERY: result_ff <= {{16{level_ff[15]}}, level_ff};
          `LSTW_CMD_LEVEL_MAX_QUERY: result_ff <= {{16{LEVEL_MAX[15]}}, LEVEL_MAX};
          `LSTW_CMD_LEVEL_MIN_QUERY: result_ff <= {{16{LEVEL_MIN[15]}}, LEVEL_MIN};
          default: begin
            result_ff <= result_ff;
          end
        endcase
        if (wait_ok) begin
          out_level_ff <= arg16;
          wcnt_ff <= 32'h0000_0001;
          wtype_ff <= (cmd == `LSTW_CMD_WAIT_HIGH) ? WT_HIGH :
                      (cmd == `LSTW_CMD_WAIT_FALL) ? WT_FALL : WT_LOW;
          if (!skip_now) begin
            state_ff <= ST_WAIT;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Software registers and interrupt
  // ----------------------------------------
  wire [2:0] irq_evt = {err_evt, step_evt, busy & step_done};
  wire [31:0] sweep_w = wmask({stop_ang_ff, start_ang_ff}, wb_dat_i, wb_sel_i);
  wire [15:0] ang_start_w = sweep_w[15:0];

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      arg_ff <= 32'h0000_0000;
      wait_ff <= 32'h0000_0000;
      dwell_ff <= {PTR_W{1'b0}};
      irq_stat_ff <= 3'h0;
      irq_en_ff <= 3'h0;
      start_ang_ff <= `LSTW_RST_START_ANG;
      stop_ang_ff <= `LSTW_RST_STOP_ANG;
    end else begin
      if (wr && wb_adr_i == `LSTW_ADR_ARG) begin
        arg_ff <= wmask(arg_ff, wb_dat_i, wb_sel_i);
      end
      if (wr && wb_adr_i == `LSTW_ADR_WAIT && !busy) begin
        wait_ff <= wmask(wait_ff, wb_dat_i, wb_sel_i);
      end
      if (wr && wb_adr_i == `LSTW_ADR_DWELL) begin
        dwell_ff <= wb_dat_i[PTR_W-1:0];
      end
      if (wr && wb_adr_i == `LSTW_ADR_IRQ_EN) begin
        irq_en_ff <= wb_dat_i[2:0];
      end
      // Angles outside the legal range are ignored so the query always reports valid values
      if (wr && wb_adr_i == `LSTW_ADR_SWEEP && ang_ok(sweep_w[15:0]) && ang_ok(sweep_w[31:16])) begin
        start_ang_ff <= ang_start_w;
        stop_ang_ff <= sweep_w[31:16];
      end
      // Set wins over a clear in the same cycle
      if (wr && wb_adr_i == `LSTW_ADR_IRQ_CLR) begin
        irq_stat_ff <= (irq_stat_ff & ~wb_dat_i[2:0]) | irq_evt;
      end else begin
        irq_stat_ff <= irq_stat_ff | irq_evt;
      end
    end
  end

  assign irq = |(irq_stat_ff & irq_en_ff);

  // ----------------------------------------
  // Read mux and acknowledge
  // ----------------------------------------
  reg [31:0] nxt_rdata;
  always @* begin
    case (wb_adr_i)
      `LSTW_ADR_ARG: nxt_rdata = arg_ff;
      `LSTW_ADR_STAT: nxt_rdata = {28'h0000000, hi_stable, append_current_point_ff, list_volt_ff, busy};
      `LSTW_ADR_RESULT: nxt_rdata = result_ff;
      `LSTW_ADR_RESULT2: nxt_rdata = result2_ff;
      `LSTW_ADR_WAIT: nxt_rdata = wait_ff;
      `LSTW_ADR_DWELL: nxt_rdata = {{(32-PTR_W){1'b0}}, dwell_ff};
      `LSTW_ADR_LEVEL: nxt_rdata = {16'h0000, level_ff};
      `LSTW_ADR_ERR: nxt_rdata = {16'h0000, err_ff};
      `LSTW_ADR_IRQ_STAT: nxt_rdata = {29'h00000000, irq_stat_ff};
      `LSTW_ADR_IRQ_EN: nxt_rdata = {29'h00000000, irq_en_ff};
      `LSTW_ADR_SWEEP: nxt_rdata = {stop_ang_ff, start_ang_ff};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (rd) begin
        wb_dat_o <= nxt_rdata;
      end
    end
  end

endmodule

// *** lstw_trig_filter.v ***
// Trigger input synchroniser, stability filter and falling-edge detector
`timescale 1ns/100ps
module lstw_trig_filter #(
  parameter CNT_W = 15
) (
  // Clock and reset
  input wire clk_sys,
  input wire arst_n,
  // Raw pin and filter length
  input wire trig_pin,
  input wire [CNT_W-1:0] filt_cyc,
  // Filtered results
  output reg stable_ff,
  output wire fall
);

  reg sync1_ff;
  reg sync2_ff;
  reg prev_ff;
  reg [CNT_W-1:0] cnt_ff;
  wire [CNT_W-1:0] nxt_cnt;

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
    end else begin
      sync1_ff <= trig_pin;
      sync2_ff <= sync1_ff;
    end
  end

  // ----------------------------------------
  // Level counts as stable only after filt_cyc cycles unchanged
  // ----------------------------------------
  assign nxt_cnt = (sync2_ff == stable_ff) ? {CNT_W{1'b0}} : cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= {CNT_W{1'b0}};
      stable_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else begin
      prev_ff <= stable_ff;
      if (sync2_ff != stable_ff && nxt_cnt >= filt_cyc) begin
        stable_ff <= sync2_ff;
        cnt_ff <= {CNT_W{1'b0}};
      end else begin
        cnt_ff <= nxt_cnt;
      end
    end
  end

  // The filtered level resets high, so an input low from the start still counts as a fall once filtered
  assign fall = prev_ff & ~stable_ff;

endmodule

// *** lstw_trig_src.sv ***
// External trigger source model
`timescale 1ns/100ps
module lstw_trig_src #(
  parameter MIN_HOLD = 28
) (
  // Clock
  input wire clk_sys,
  // Trigger pin, idles high like an open input
  output reg trig_in
);
  initial trig_in = 1'b1;
  // Never shorter than the filter, so each level is seen as stable
  task automatic hold(input logic lvl, input integer cyc);
    integer n;
    begin
      @(posedge clk_sys);
      trig_in <= lvl;
      n = (cyc < MIN_HOLD) ? MIN_HOLD : cyc;
      repeat (n) @(posedge clk_sys);
    end
  endtask
endmodule
